// file: bit_ops_top.sv
// Contract
// - bit clear on accumulator, sz flags, 2 cycles
// - bit invert on accumulator, sz flags, 2 cycles
// - bit set on accumulator, sz flags, 2 cycles
// - clear accumulator to zero, 1 cycle
// - slow clock op keeps flags, 3 cycles
// - clear carry and overflow only, 1 cycle
// - restart watchdog, nothing else changes (here the sticky watchdog seen status bit is also set)
// - accumulators are 24-bit two's complement
// - flags follow latest affecting operation
//
// Design decisions made here: register access over APB and the placing of the registers.
module bit_ops_top
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             slow_clock_on,
   output logic             wdt_clear
);
   import bit_ops_pkg::*;

   exec_if e ();

   logic [WORD_W-1:0] acc [4];
   logic              flag_c;
   logic              flag_o;
   logic              flag_s;
   logic              flag_z;
   logic              cmd_err;
   logic              wdt_seen;

   state_e            state;
   logic [1:0]        count;

   // command latched at accept, held for the whole execution
   op_e               cur_op;
   logic [1:0]        cur_sel;
   logic [POS_W-1:0]  cur_pos;
   logic              cur_arg;

   bit_alu bit_alu_inst (
      .e (e.alu)
   );

   function automatic logic is_acc(input logic [11:0] a);
      is_acc = (a[11:4] == OFS_ACC0[11:4]) && (a[1:0] == 2'b00);
   endfunction : is_acc

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == OFS_CMD) || (a == OFS_STATUS) || is_acc(a);
   endfunction : mapped

   wire             access    = psel && penable;
   wire             busy      = (state == ST_EXEC);
   wire             wr_cmd    = access && pwrite && (paddr == OFS_CMD);
   wire             wr_status = access && pwrite && (paddr == OFS_STATUS);
   wire [2:0]       new_op    = pwdata[CMD_OP_LSB +: 3];
   wire [1:0]       new_sel   = pwdata[CMD_SEL_LSB +: 2];
   wire [POS_W-1:0] new_pos   = pwdata[CMD_ARG_LSB +: POS_W];
   wire             new_arg   = pwdata[CMD_ARG_LSB];
   wire             bad_pos   = (new_pos > POS_MAX) && (new_op <= 3'd2);
   wire             bad_op    = new_op >= 3'd7;
   wire             accept    = wr_cmd && !busy && !bad_pos && !bad_op;
   wire             finish    = busy && (count == 2'd1);

   // writes to an accumulator while busy would race the write-back
   wire busy_wr = access && pwrite && busy && (wr_cmd || is_acc(paddr));

   // c and o come from instructions outside this block; software loads them here,
   // idle only, so a running flag clear is never undone
   wire sw_flag_wr = wr_status && !busy;

   // zero wait states: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign pslverr = access && (!mapped(paddr) || busy_wr || (wr_cmd && (bad_pos || bad_op)));

   assign e.start   = finish;
   assign e.op      = cur_op;
   assign e.operand = acc[cur_sel];
   assign e.pos     = cur_pos;
   assign e.arg     = cur_arg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state   <= ST_IDLE;
         count   <= 2'd0;
         cur_op  <= OP_NONE;
         cur_sel <= 2'd0;
         cur_pos <= '0;
         cur_arg <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (accept) begin
                  state   <= ST_EXEC;
                  cur_op  <= op_e'(new_op);
                  cur_sel <= new_sel;
                  cur_pos <= new_pos;
                  cur_arg <= new_arg;
               end
            end
            ST_EXEC: begin
               // count 0 on entry: the length comes from the alu one cycle later
               if (count == 2'd0) begin
                  count <= e.cycles;
               end else if (finish) begin
                  state  <= ST_IDLE;
                  count  <= 2'd0;
                  cur_op <= OP_NONE;
               end else begin
                  count <= count - 2'd1;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // per-accumulator write-back, software write when idle
   for (genvar i = 0; i < 4; i++) begin : g_acc
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            acc[i] <= ACC_RESET;
         end else if (finish && e.writes_acc && (cur_sel == 2'(i))) begin
            acc[i] <= e.result;
         end else if (access && pwrite && !busy && is_acc(paddr)
                      && (paddr[3:2] == 2'(i))) begin
            acc[i] <= pwdata[WORD_W-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_s <= 1'b0;
         flag_z <= 1'b0;
      end else if (finish && e.sz_update) begin
         flag_s <= e.result[WORD_W-1];
         flag_z <= (e.result == ACC_RESET);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_c <= 1'b0;
         flag_o <= 1'b0;
      end else if (finish && e.co_clear) begin
         flag_c <= 1'b0;
         flag_o <= 1'b0;
      end else if (sw_flag_wr) begin
         flag_c <= pwdata[ST_C];
         flag_o <= pwdata[ST_O];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slow_clock_on <= 1'b0;
      end else if (finish && e.slow_write) begin
         slow_clock_on <= e.result[0];
      end
   end

   // one-cycle restart pulse for the external watchdog counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_clear <= 1'b0;
      end else begin
         wdt_clear <= finish && e.wdt_pulse;
      end
   end

   // sticky seen bit: set wins over the write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_seen <= 1'b0;
      end else if (finish && e.wdt_pulse) begin
         wdt_seen <= 1'b1;
      end else if (wr_status && pwdata[ST_WDT]) begin
         wdt_seen <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_err <= 1'b0;
      end else if (wr_cmd && (bad_pos || bad_op || busy)) begin
         cmd_err <= 1'b1;
      end else if (wr_status && pwdata[ST_ERR]) begin
         cmd_err <= 1'b0;
      end
   end

   // read data only in the access phase, zero otherwise
   always_comb begin
      prdata = 32'h0000_0000;
      if (access && !pwrite) begin
         if (paddr == OFS_STATUS) begin
            prdata[ST_BUSY] = busy;
            prdata[ST_SLOW] = slow_clock_on;
            prdata[ST_C]    = flag_c;
            prdata[ST_O]    = flag_o;
            prdata[ST_S]    = flag_s;
            prdata[ST_Z]    = flag_z;
            prdata[ST_WDT]  = wdt_seen;
            prdata[ST_ERR]  = cmd_err;
         end else if (is_acc(paddr)) begin
            prdata[WORD_W-1:0] = acc[paddr[3:2]];
         end
      end
   end
endmodule : bit_ops_top

// file: bit_ops_pkg.sv
package bit_ops_pkg;
   localparam int WORD_W = 24;
   localparam int POS_W  = 5;
   localparam logic [POS_W-1:0] POS_MAX = 5'd23;

   // register offsets (byte addresses)
   localparam logic [11:0] OFS_CMD    = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_ACC0   = 12'h010;

   // cmd word fields
   localparam int CMD_OP_LSB  = 0;
   localparam int CMD_SEL_LSB = 4;
   localparam int CMD_ARG_LSB = 8;

   // status word fields
   localparam int ST_BUSY = 0;
   localparam int ST_SLOW = 1;
   localparam int ST_C    = 4;
   localparam int ST_O    = 5;
   localparam int ST_S    = 6;
   localparam int ST_Z    = 7;
   localparam int ST_WDT  = 8;
   localparam int ST_ERR  = 9;

   // execution lengths in cycles
   localparam logic [1:0] CYC_BIT   = 2'd2;
   localparam logic [1:0] CYC_CLEAR = 2'd1;
   localparam logic [1:0] CYC_SLOW  = 2'd3;
   localparam logic [1:0] CYC_FLAG  = 2'd1;
   localparam logic [1:0] CYC_WDT   = 2'd2;

   localparam logic [WORD_W-1:0] ACC_RESET = 24'h00_0000;

   typedef enum logic [2:0] {
      OP_BIT_CLR, OP_BIT_INV, OP_BIT_SET, OP_REG_CLEAR,
      OP_SLOW_CLOCK_SELECT, OP_CARRY_OVERFLOW_RESET, OP_WDT_CLEAR, OP_NONE
   } op_e;

   typedef enum logic [0:0] {
      ST_IDLE, ST_EXEC
   } state_e;
endpackage : bit_ops_pkg

// file: exec_if.sv
interface exec_if;
   import bit_ops_pkg::*;
   logic              start;
   op_e               op;
   logic [WORD_W-1:0] operand;
   logic [POS_W-1:0]  pos;
   logic              arg;
   logic [WORD_W-1:0] result;
   logic              writes_acc;
   logic              sz_update;
   logic              co_clear;
   logic              slow_write;
   logic              wdt_pulse;
   logic [1:0]        cycles;
   modport ctrl (output start, op, operand, pos, arg,
                 input result, writes_acc, sz_update, co_clear, slow_write, wdt_pulse, cycles);
   modport alu  (input start, op, operand, pos, arg,
                 output result, writes_acc, sz_update, co_clear, slow_write, wdt_pulse, cycles);
endinterface : exec_if

// file: bit_alu.sv
module bit_alu
   import bit_ops_pkg::*;
(
   exec_if.alu e
);
   function automatic logic [WORD_W-1:0] one_hot(input logic [POS_W-1:0] p);
      one_hot = {{(WORD_W-1){1'b0}}, 1'b1} << p;
   endfunction : one_hot

   always_comb begin
      e.result     = e.operand;
      e.writes_acc = 1'b0;
      e.sz_update  = 1'b0;
      e.co_clear   = 1'b0;
      e.slow_write = 1'b0;
      e.wdt_pulse  = 1'b0;
      e.cycles     = CYC_CLEAR;
      case (e.op)
         OP_BIT_CLR: begin
            e.result     = e.operand & ~one_hot(e.pos);
            e.writes_acc = 1'b1;
            e.sz_update  = 1'b1;
            e.cycles     = CYC_BIT;
         end
         OP_BIT_INV: begin
            e.result     = e.operand ^ one_hot(e.pos);
            e.writes_acc = 1'b1;
            e.sz_update  = 1'b1;
            e.cycles     = CYC_BIT;
         end
         OP_BIT_SET: begin
            e.result     = e.operand | one_hot(e.pos);
            e.writes_acc = 1'b1;
            e.sz_update  = 1'b1;
            e.cycles     = CYC_BIT;
         end
         OP_REG_CLEAR: begin
            e.result     = ACC_RESET;
            e.writes_acc = 1'b1;
            e.sz_update  = 1'b1;
            e.cycles     = CYC_CLEAR;
         end
         OP_SLOW_CLOCK_SELECT: begin
            e.result     = {{(WORD_W-1){1'b0}}, e.arg};
            e.slow_write = 1'b1;
            e.cycles     = CYC_SLOW;
         end
         OP_CARRY_OVERFLOW_RESET: begin
            e.co_clear = 1'b1;
            e.cycles   = CYC_FLAG;
         end
         OP_WDT_CLEAR: begin
            e.wdt_pulse = 1'b1;
            e.cycles    = CYC_WDT;
         end
         default: begin
            e.result = e.operand;
         end
      endcase
      // effects only on the finishing cycle; cycles stays valid for the length load
      if (!e.start) begin
         e.writes_acc = 1'b0;
         e.sz_update  = 1'b0;
         e.co_clear   = 1'b0;
         e.slow_write = 1'b0;
         e.wdt_pulse  = 1'b0;
      end
   end
endmodule : bit_alu

// file: bit_ops_asserts.sv
module bit_ops_asserts
   import bit_ops_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        slow_clock_on,
   input wire logic        wdt_clear
);
   wire acc_ph = psel && penable;
   wire cmd_wr = acc_ph && pwrite && paddr == OFS_CMD;
   wire cmd_ok = cmd_wr && !pslverr;
   wire op4    = cmd_ok && pwdata[2:0] == 3'h4;
   wire op6    = cmd_ok && pwdata[2:0] == 3'h6;
   logic [3:0] scnt;
   logic [3:0] wcnt;
   logic       sarg;
   // windows in which a clock change or a watchdog pulse may legally appear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scnt <= 4'h0;
         wcnt <= 4'h0;
         sarg <= 1'b0;
      end else begin
         scnt <= op4 ? 4'h8 : scnt - {3'h0, scnt != 4'h0};
         wcnt <= op6 ? 4'h8 : wcnt - {3'h0, wcnt != 4'h0};
         sarg <= op4 ? pwdata[8] : sarg;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence slow_done;
      ##[3:6] slow_clock_on == sarg;
   endsequence
   sequence wdt_pulse;
      ##[2:6] wdt_clear ##1 !wdt_clear;
   endsequence
   AST_SLOW_SELECT: assert property (op4 |-> slow_done)
      else $error("slow clock select not applied");
   AST_SLOW_STATUS: assert property (acc_ph && !pwrite && paddr == OFS_STATUS |-> prdata[ST_SLOW] == slow_clock_on)
      else $error("status slow bit differs from output");
   AST_SLOW_CAUSE: assert property ($changed(slow_clock_on) |-> scnt != 4'h0)
      else $error("clock selection changed with no command");
   AST_SLOW_BUSY: assert property (op4 |-> ##2 !cmd_ok)
      else $error("command accepted during slow clock op");
   AST_WDT_PULSE: assert property (op6 |-> wdt_pulse)
      else $error("watchdog pulse missing or too long");
   AST_WDT_CAUSE: assert property ($rose(wdt_clear) |-> wcnt != 4'h0)
      else $error("watchdog pulse with no command");
   AST_WDT_KEEP: assert property (op6 |-> $stable(slow_clock_on)[*6])
      else $error("watchdog clear touched clock selection");
   AST_POS_RANGE: assert property (cmd_wr && pwdata[2:0] < 3'h3 && pwdata[12:8] > POS_MAX |-> pslverr)
      else $error("bit position above range accepted");
   AST_ACC_WIDTH: assert property (acc_ph && !pwrite && paddr[11:4] == 8'h01 |-> prdata[31:24] == 8'h00)
      else $error("accumulator wider than its word");
endmodule : bit_ops_asserts

bind bit_ops_top bit_ops_asserts bit_ops_asserts_inst (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .slow_clock_on, .wdt_clear);

// file: bitwise_flag_clock_ops_test.sv
module bitwise_flag_clock_ops_test;
   timeunit 1ns;
   timeprecision 1ps;
   import bit_ops_pkg::*;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        slow_clock_on;
   logic        wdt_clear;
   logic [31:0] rdat;
   logic        rerr;
   int          err_count  = 0;
   int          n_compared = 0;
   int          pulses     = 0;
   always #4 pclk = ~pclk;
   always @(posedge pclk) pulses <= pulses + int'(wdt_clear === 1'b1);
   bit_ops_top bit_ops_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .slow_clock_on, .wdt_clear);

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one idle cycle after each transfer keeps psel from being driven twice per step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n == 20) begin
         err_count++;
         finish_test();
      end
      @(posedge pclk);
   endtask : apb

   task automatic cmd(input logic [2:0] op, input logic [1:0] sel, input logic [4:0] arg,
                      input logic err);
      int n;
      n = 0;
      apb(1'b1, OFS_CMD, {19'h0, arg, 2'h0, sel, 1'b0, op});
      chk("refusal", {31'h0, err}, {31'h0, rerr});
      do begin
         apb(1'b0, OFS_STATUS, 32'h0);
         n++;
      end while (rdat[ST_BUSY] !== 1'b0 && n < 20);
      if (n == 20) begin
         err_count++;
         finish_test();
      end
   endtask : cmd

   // carry and overflow must read zero whenever an accumulator is checked
   task automatic chk_acc(input logic [1:0] sel, input logic [23:0] exp);
      apb(1'b0, OFS_ACC0 + {8'h0, sel, 2'h0}, 32'h0);
      chk("accumulator", {8'h0, exp}, rdat);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("flags", {28'h0, exp == 24'h0, exp[23], 2'b00}, {28'h0, rdat[ST_Z:ST_C]});
   endtask : chk_acc

   task automatic t_bits;
      for (int s = 0; s < 4; s++) begin
         cmd(3'h3, 2'(s), 5'h0, 1'b0);
         chk_acc(2'(s), 24'h00_0000);
         cmd(3'h2, 2'(s), 5'd23, 1'b0);
         chk_acc(2'(s), 24'h80_0000);
         cmd(3'h1, 2'(s), 5'd23, 1'b0);
         chk_acc(2'(s), 24'h00_0000);
      end
      for (int p = 0; p < 24; p++) cmd(3'h2, 2'h1, 5'(p), 1'b0);
      chk_acc(2'h1, 24'hFF_FFFF);
      for (int p = 0; p < 24; p += 2) cmd(3'h1, 2'h1, 5'(p), 1'b0);
      chk_acc(2'h1, 24'hAA_AAAA);
      for (int p = 1; p < 24; p += 2) cmd(3'h0, 2'h1, 5'(p), 1'b0);
      chk_acc(2'h1, 24'h00_0000);
      $display("test bits done");
   endtask : t_bits

   task automatic t_misc;
      int p;
      apb(1'b1, OFS_ACC0 + 12'h004, 32'h0012_3456);
      apb(1'b0, OFS_ACC0 + 12'h004, 32'h0);
      chk("acc write", 32'h0012_3456, rdat);
      cmd(3'h3, 2'h1, 5'h0, 1'b0);
      chk_acc(2'h1, 24'h00_0000);
      cmd(3'h2, 2'h0, 5'd23, 1'b0);
      apb(1'b1, OFS_STATUS, 32'h0000_0030);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("flags loaded", 32'h0000_0070, {24'h0, rdat[ST_Z:ST_C], 4'h0});
      cmd(3'h5, 2'h0, 5'h0, 1'b0);
      chk_acc(2'h0, 24'h80_0000);
      cmd(3'h4, 2'h0, 5'h1, 1'b0);
      chk("slow select", 32'h1, {31'h0, slow_clock_on});
      chk_acc(2'h0, 24'h80_0000);
      p = pulses;
      cmd(3'h6, 2'h0, 5'h0, 1'b0);
      chk("wdt pulses", 32'h1, 32'(pulses - p));
      chk_acc(2'h0, 24'h80_0000);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("wdt seen", 32'h1, {31'h0, rdat[ST_WDT]});
      apb(1'b1, OFS_STATUS, 32'h0000_0100);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("wdt seen clear", 32'h0, {31'h0, rdat[ST_WDT]});
      cmd(3'h4, 2'h0, 5'h0, 1'b0);
      chk("slow select", 32'h0, {31'h0, slow_clock_on});
      $display("test misc done");
   endtask : t_misc

   task automatic t_refuse;
      cmd(3'h3, 2'h2, 5'h0, 1'b0);
      cmd(3'h2, 2'h2, 5'd24, 1'b1);
      cmd(3'h7, 2'h2, 5'h0, 1'b1);
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped", 32'h1, {31'h0, rerr});
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("cmd error", 32'h1, {31'h0, rdat[ST_ERR]});
      apb(1'b1, OFS_STATUS, 32'h0000_0200);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("cmd error clear", 32'h0, {31'h0, rdat[ST_ERR]});
      apb(1'b1, OFS_CMD, 32'h0000_0104);
      cmd(3'h2, 2'h2, 5'h5, 1'b1);
      chk("slow select", 32'h1, {31'h0, slow_clock_on});
      chk_acc(2'h2, 24'h00_0000);
      cmd(3'h4, 2'h0, 5'h0, 1'b0);
      $display("test refuse done");
   endtask : t_refuse

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_bits();
      t_misc();
      t_refuse();
      cmd(3'h6, 2'h0, 5'h0, 1'b0);
      finish_test();
   end
endmodule : bitwise_flag_clock_ops_test
